// >>> rtl/i2cis_map.vh
`ifndef I2CIS_MAP_VH
`define I2CIS_MAP_VH

`define I2CIS_ADDR_W          8
`define I2CIS_OFS_MASK        8'h30
`define I2CIS_OFS_RAW         8'h34
`define I2CIS_OFS_RECEIVE_THRESHOLD_LEVEL       8'h38
`define I2CIS_OFS_TRANSMIT_THRESHOLD_LEVEL       8'h3c
`define I2CIS_OFS_CLR_ALL     8'h40
`define I2CIS_OFS_CLR_RX_UND  8'h44
`define I2CIS_OFS_MASKED      8'h2c

`define I2CIS_NSRC            12
`define I2CIS_BIT_GENERAL_CALL_SEEN    11
`define I2CIS_BIT_START       10
`define I2CIS_BIT_STOP        9
`define I2CIS_BIT_ACTIVITY    8
`define I2CIS_BIT_TX_DONE     7
`define I2CIS_BIT_TX_ABORT    6
`define I2CIS_BIT_RD_REQ      5
`define I2CIS_BIT_TX_THR      4
`define I2CIS_BIT_TX_OVER     3
`define I2CIS_BIT_RX_THR      2
`define I2CIS_BIT_RX_OVER     1
`define I2CIS_BIT_RX_UNDER    0

`define I2CIS_MASK_RESET      12'h8ff
`define I2CIS_TL_RESET        8'h00
`define I2CIS_LVL_W           8

`endif

// >>> rtl/i2cis_intr_status.v
`timescale 1ns/1ns
`include "i2cis_map.vh"

// Interrupt, status and FIFO threshold registers of the I2C controller.
module i2cis_intr_status (
    // Clock, reset and clock enable.
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // Register bus.
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    // Bus condition and slave events on this clock; all are one-cycle pulses except the busy level bus_active_i.
    input  wire        general_call_seen_ack_i,
    input  wire        start_cond_i,
    input  wire        stop_cond_i,
    input  wire        bus_active_i,
    input  wire        slv_tx_nack_i,
    input  wire        tx_abort_i,
    input  wire        slv_rd_req_i,
    // Data register accesses and FIFO state from the data path.
    input  wire        data_cmd_wr_i,
    input  wire        data_cmd_rd_i,
    input  wire        rx_byte_in_i,
    input  wire        tx_full_i,
    input  wire        rx_full_i,
    input  wire        rx_empty_i,
    input  wire [7:0]  tx_level_i,
    input  wire [7:0]  rx_level_i,
    // Outputs to the rest of the controller.
    output wire        abort_cause_clr_o,
    output wire [7:0]  receive_threshold_level_o,
    output wire [7:0]  transmit_threshold_level_o,
    output wire        irq_o
);

    // Register state; each one is written by its own clocked process below.
    reg  [11:0] sticky_ff;
    reg  [11:0] interrupt_mask_ff;
    reg  [7:0]  receive_threshold_level_ff;
    reg  [7:0]  transmit_threshold_level_ff;
    reg         act_prev_ff;

    // Reset values of the register state.
    localparam [11:0] MASK_RST   = `I2CIS_MASK_RESET;
    localparam [7:0]  TL_RST     = `I2CIS_TL_RESET;
    localparam [11:0] STICKY_RST = 12'h000;
    localparam [31:0] RDATA_RST  = 32'h0000_0000;

    // Next values of the register state.
    wire [11:0] nxt_sticky;
    reg  [11:0] nxt_mask;
    reg  [7:0]  nxt_receive_threshold_level;
    reg  [7:0]  nxt_transmit_threshold_level;

    // Next values of the helper flip-flops.
    wire        nxt_act_prev;
    reg  [31:0] nxt_rdata;

    // Event sources seen on the bus side.
    wire        ev_general_call_seen;
    wire        ev_start;
    wire        ev_stop;
    wire        ev_act_rise;
    wire        ev_tx_done;
    wire        ev_tx_abort;
    wire        ev_rd_req;

    // Event sources seen on the FIFO side.
    wire        ev_tx_over;
    wire        ev_rx_over;
    wire        ev_rx_under;

    // Status vectors in the layout of the raw status register.
    wire [11:0] evt;
    wire [11:0] clr_vec;
    wire [11:0] raw_interrupt_status;
    wire [11:0] masked_status;
    wire        tx_below_thr;
    wire        rx_above_thr;

    // Qualified strobes.
    wire        bus_rd;
    wire        bus_wr;

    // Register selects.
    wire        sel_masked;
    wire        sel_mask;
    wire        sel_raw;
    wire        sel_receive_threshold_level;
    wire        sel_transmit_threshold_level;
    wire        sel_clr_all;
    wire        sel_clr_rx_und;

    // Clear and write enables.
    wire        clr_all;
    wire        clr_rx_under;
    wire        wr_mask;
    wire        wr_receive_threshold_level;
    wire        wr_transmit_threshold_level;

    // Write data cut to the stored field widths.
    wire [11:0] wd_mask;
    wire [7:0]  wd_receive_threshold_level;
    wire [7:0]  wd_transmit_threshold_level;

    // Read data, one word per readable register.
    wire [31:0] rd_masked;
    wire [31:0] rd_mask;
    wire [31:0] rd_raw;
    wire [31:0] rd_receive_threshold_level;
    wire [31:0] rd_transmit_threshold_level;
    wire [31:0] rd_clr_all;
    wire [31:0] rd_clr_rx_und;

    // A strobe counts only while the clock enable is high, so a frozen block ignores clears as well.
    assign bus_rd = ce_i & rd_i;
    assign bus_wr = ce_i & wr_i;

    // Every select compares the full byte address, so no register is mirrored elsewhere.
    assign sel_masked     = (addr_i == `I2CIS_OFS_MASKED);
    assign sel_mask       = (addr_i == `I2CIS_OFS_MASK);
    assign sel_raw        = (addr_i == `I2CIS_OFS_RAW);
    assign sel_receive_threshold_level      = (addr_i == `I2CIS_OFS_RECEIVE_THRESHOLD_LEVEL);
    assign sel_transmit_threshold_level      = (addr_i == `I2CIS_OFS_TRANSMIT_THRESHOLD_LEVEL);
    assign sel_clr_all    = (addr_i == `I2CIS_OFS_CLR_ALL);
    assign sel_clr_rx_und = (addr_i == `I2CIS_OFS_CLR_RX_UND);

    // Reading a clear register is what clears it; the read data are only informative.
    assign clr_all      = bus_rd & sel_clr_all;
    assign clr_rx_under = bus_rd & sel_clr_rx_und;

    // Writes to read-only or unmapped offsets match no enable and are ignored.
    assign wr_mask  = bus_wr & sel_mask;
    assign wr_receive_threshold_level = bus_wr & sel_receive_threshold_level;
    assign wr_transmit_threshold_level = bus_wr & sel_transmit_threshold_level;

    // Upper write bits are dropped; they read back as zero.
    assign wd_mask  = wdata_i[11:0];
    assign wd_receive_threshold_level = wdata_i[7:0];
    assign wd_transmit_threshold_level = wdata_i[7:0];

    // The abort cause register lives outside this block and is cleared by the same read.
    assign abort_cause_clr_o = clr_all;

    // Event inputs come from logic on this clock and are one-cycle pulses, apart from the busy level, so no synchroniser is used.
    // General call: the address was received and acknowledged.
    assign ev_general_call_seen = general_call_seen_ack_i;
    // A START or repeated START was seen on the bus.
    assign ev_start = start_cond_i;
    // A STOP was seen on the bus.
    assign ev_stop = stop_cond_i;
    // Activity sets once on the rising edge of the busy level, not on every busy cycle.
    assign ev_act_rise = bus_active_i & ~act_prev_ff;
    // As slave transmitter, the remote master left a sent byte unacknowledged.
    assign ev_tx_done = slv_tx_nack_i;
    // Queued transmit work could not be completed.
    assign ev_tx_abort = tx_abort_i;
    // Addressed as slave, a remote master asks for data.
    assign ev_rd_req = slv_rd_req_i;
    // A command was written while the transmit FIFO was full.
    assign ev_tx_over = data_cmd_wr_i & tx_full_i;
    // A byte arrived while the receive FIFO was full.
    assign ev_rx_over = rx_byte_in_i & rx_full_i;
    // The data register was read while the receive FIFO was empty.
    assign ev_rx_under = data_cmd_rd_i & rx_empty_i;

    // Threshold positions carry no event; their status bits are live levels.
    assign evt[`I2CIS_BIT_GENERAL_CALL_SEEN] = ev_general_call_seen;
    assign evt[`I2CIS_BIT_START]    = ev_start;
    assign evt[`I2CIS_BIT_STOP]     = ev_stop;
    assign evt[`I2CIS_BIT_ACTIVITY] = ev_act_rise;
    assign evt[`I2CIS_BIT_TX_DONE]  = ev_tx_done;
    assign evt[`I2CIS_BIT_TX_ABORT] = ev_tx_abort;
    assign evt[`I2CIS_BIT_RD_REQ]   = ev_rd_req;
    assign evt[`I2CIS_BIT_TX_THR]   = 1'b0;
    assign evt[`I2CIS_BIT_TX_OVER]  = ev_tx_over;
    assign evt[`I2CIS_BIT_RX_THR]   = 1'b0;
    assign evt[`I2CIS_BIT_RX_OVER]  = ev_rx_over;
    assign evt[`I2CIS_BIT_RX_UNDER] = ev_rx_under;

    // The threshold bits follow the FIFO levels directly, so no clear can hide them.
    // Both compare inclusively, so an idle block with zero thresholds shows both.
    assign tx_below_thr = (tx_level_i <= transmit_threshold_level_ff);
    assign rx_above_thr = (rx_level_i >= receive_threshold_level_ff);

    // Clear-all hits every sticky bit; the underflow clear hits bit 0 only.
    assign clr_vec = {12{clr_all}} | {11'h000, clr_rx_under};

    // One status cell per source. A set in the same cycle as a clear wins,
    // so an event that lands on the clearing read is never lost.
    genvar gi;
    generate
        for (gi = 0; gi < `I2CIS_NSRC; gi = gi + 1) begin : g_src
            if ((gi == `I2CIS_BIT_TX_THR) || (gi == `I2CIS_BIT_RX_THR)) begin : g_live
                // Live cells keep no state; their flip-flop input is tied low.
                assign nxt_sticky[gi]           = 1'b0;
                assign raw_interrupt_status[gi] = (gi == `I2CIS_BIT_TX_THR) ? tx_below_thr : rx_above_thr;
            end else begin : g_held
                assign nxt_sticky[gi]           = evt[gi] | (sticky_ff[gi] & ~clr_vec[gi]);
                assign raw_interrupt_status[gi] = sticky_ff[gi];
            end
            assign masked_status[gi] = raw_interrupt_status[gi] & interrupt_mask_ff[gi];
        end
    endgenerate

    // The interrupt line is a plain OR, so it drops in the cycle its last enabled bit clears.
    assign irq_o = |masked_status;

    // Threshold values go to the FIFO logic straight from the flip-flops.
    assign receive_threshold_level_o  = receive_threshold_level_ff;
    assign transmit_threshold_level_o = transmit_threshold_level_ff;

    // A mask write lands at the edge that samples the strobe.
    always @* begin
        if (wr_mask) begin
            nxt_mask = wd_mask;
        end else begin
            nxt_mask = interrupt_mask_ff;
        end
    end

    // The receive threshold takes any 8-bit value; no range is enforced.
    always @* begin
        if (wr_receive_threshold_level) begin
            nxt_receive_threshold_level = wd_receive_threshold_level;
        end else begin
            nxt_receive_threshold_level = receive_threshold_level_ff;
        end
    end

    // The transmit threshold takes any 8-bit value; no range is enforced.
    always @* begin
        if (wr_transmit_threshold_level) begin
            nxt_transmit_threshold_level = wd_transmit_threshold_level;
        end else begin
            nxt_transmit_threshold_level = transmit_threshold_level_ff;
        end
    end

    // The busy level is remembered every enabled cycle to find its rising edge.
    assign nxt_act_prev = bus_active_i;

    // Clear registers return the state seen just before they clear it.
    assign rd_masked     = {20'h00000, masked_status};
    assign rd_mask       = {20'h00000, interrupt_mask_ff};
    assign rd_raw        = {20'h00000, raw_interrupt_status};
    assign rd_receive_threshold_level      = {24'h000000, receive_threshold_level_ff};
    assign rd_transmit_threshold_level      = {24'h000000, transmit_threshold_level_ff};
    assign rd_clr_all    = {31'h00000000, irq_o};
    assign rd_clr_rx_und = {31'h00000000, raw_interrupt_status[`I2CIS_BIT_RX_UNDER]};

    // Read data stand from the edge after the strobe until the next enabled edge, and are zero when that edge samples no read.
    always @* begin
        nxt_rdata = RDATA_RST;
        if (rd_i) begin
            case (addr_i)
                // Masked status, read only.
                `I2CIS_OFS_MASKED: begin
                    nxt_rdata = rd_masked;
                end
                // Mask register.
                `I2CIS_OFS_MASK: begin
                    nxt_rdata = rd_mask;
                end
                // Raw status, read only.
                `I2CIS_OFS_RAW: begin
                    nxt_rdata = rd_raw;
                end
                // Receive threshold.
                `I2CIS_OFS_RECEIVE_THRESHOLD_LEVEL: begin
                    nxt_rdata = rd_receive_threshold_level;
                end
                // Transmit threshold.
                `I2CIS_OFS_TRANSMIT_THRESHOLD_LEVEL: begin
                    nxt_rdata = rd_transmit_threshold_level;
                end
                // Clear-all register: shows the combined interrupt.
                `I2CIS_OFS_CLR_ALL: begin
                    nxt_rdata = rd_clr_all;
                end
                // Underflow clear register: shows the underflow bit.
                `I2CIS_OFS_CLR_RX_UND: begin
                    nxt_rdata = rd_clr_rx_und;
                end
                default: begin
                    nxt_rdata = RDATA_RST;
                end
            endcase
        end
    end

    // Every register below holds still while the clock enable is low.
    // Status cells.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sticky_ff <= STICKY_RST;
        end else if (ce_i) begin
            sticky_ff <= nxt_sticky;
        end
    end

    // Interrupt mask.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            interrupt_mask_ff <= MASK_RST;
        end else if (ce_i) begin
            interrupt_mask_ff <= nxt_mask;
        end
    end

    // Receive threshold.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            receive_threshold_level_ff <= TL_RST;
        end else if (ce_i) begin
            receive_threshold_level_ff <= nxt_receive_threshold_level;
        end
    end

    // Transmit threshold.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            transmit_threshold_level_ff <= TL_RST;
        end else if (ce_i) begin
            transmit_threshold_level_ff <= nxt_transmit_threshold_level;
        end
    end

    // Busy level of the previous enabled cycle.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            act_prev_ff <= 1'b0;
        end else if (ce_i) begin
            act_prev_ff <= nxt_act_prev;
        end
    end

    // Read data register.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= RDATA_RST;
        end else if (ce_i) begin
            rdata_o <= nxt_rdata;
        end
    end

endmodule

// >>> verification/i2cis_chk.sv
`timescale 1ns/1ns
module i2cis_chk (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        ce_i,
    input wire [7:0]  addr_i,
    input wire [31:0] wdata_i,
    input wire        wr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire        start_cond_i,
    input wire [7:0]  tx_level_i,
    input wire [7:0]  rx_level_i,
    input wire        abort_cause_clr_o,
    input wire [7:0]  receive_threshold_level_o,
    input wire [7:0]  transmit_threshold_level_o,
    input wire        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_raw; ce_i && rd_i && addr_i == 8'h34; endsequence
    // A start in the clear cycle wins over the clear, so it is kept out.
    sequence s_clr; ce_i && rd_i && addr_i == 8'h40 && !start_cond_i; endsequence
    clr_pulse_a: assert property (s_clr |-> abort_cause_clr_o) else $error("no cause clear");
    clr_data_a: assert property (s_clr |=> rdata_o == {31'h0, $past(irq_o)}) else $error("clear data");
    receive_threshold_level_a: assert property (ce_i && wr_i && addr_i == 8'h38 |=>
        receive_threshold_level_o == $past(wdata_i[7:0])) else $error("rx level");
    transmit_threshold_level_a: assert property (ce_i && wr_i && addr_i == 8'h3c |=>
        transmit_threshold_level_o == $past(wdata_i[7:0])) else $error("tx level");
    tx_thr_a: assert property (s_raw |=>
        rdata_o[4] == ($past(tx_level_i) <= $past(transmit_threshold_level_o))) else $error("tx thr");
    rx_thr_a: assert property (s_raw |=>
        rdata_o[2] == ($past(rx_level_i) >= $past(receive_threshold_level_o))) else $error("rx thr");
    start_set_a: assert property (ce_i && start_cond_i ##1 s_raw |=> rdata_o[10]) else $error("start");
    clr_all_a: assert property (s_clr ##1 (s_raw ##0 !start_cond_i) |=> !rdata_o[10]) else $error("clr");
endmodule
bind i2cis_intr_status i2cis_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .start_cond_i(start_cond_i),
    .tx_level_i(tx_level_i), .rx_level_i(rx_level_i), .abort_cause_clr_o(abort_cause_clr_o), .irq_o(irq_o),
    .receive_threshold_level_o(receive_threshold_level_o), .transmit_threshold_level_o(transmit_threshold_level_o));

// >>> verification/i2cis_bus_model.sv
`timescale 1ns/1ns
// A request gives a START, then a STOP, with the bus busy across both.
module i2cis_bus_model (
    input  wire clk_i,
    input  wire go_i,
    output reg  start_o = 1'b0,
    output reg  stop_o = 1'b0,
    output wire active_o
);
    always @(posedge clk_i) begin
        start_o <= go_i;
        stop_o  <= start_o;
    end
    assign active_o = start_o | stop_o;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [11:0] ev = 12'h000;
    reg         go = 1'b0;
    reg         fl = 1'b0;
    reg  [7:0]  txl = 8'h00;
    reg  [7:0]  rxl = 8'h00;
    reg         ce = 1'b1;
    wire [31:0] rdata;
    wire        st, sp, act, irq;
    int         fails = 0;
    int         n_tests = 0;
    int         bits [7] = '{11, 7, 6, 5, 3, 1, 0};
    always #10 clk_i = ~clk_i;
    i2cis_bus_model bm (.clk_i(clk_i), .go_i(go), .start_o(st), .stop_o(sp), .active_o(act));
    i2cis_intr_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .general_call_seen_ack_i(ev[11]), .start_cond_i(st), .stop_cond_i(sp),
        .bus_active_i(act), .slv_tx_nack_i(ev[7]), .tx_abort_i(ev[6]), .slv_rd_req_i(ev[5]),
        .data_cmd_wr_i(ev[3]), .data_cmd_rd_i(ev[0]), .rx_byte_in_i(ev[1]), .tx_full_i(fl), .rx_full_i(fl),
        .rx_empty_i(fl), .tx_level_i(txl), .rx_level_i(rxl), .abort_cause_clr_o(),
        .receive_threshold_level_o(), .transmit_threshold_level_o(), .irq_o(irq));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task wreg(input [7:0] a, input [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task pulse(input [11:0] v);
        @(posedge clk_i);
        ev <= v;
        @(posedge clk_i);
        ev <= 12'h000;
    endtask
    task t_reset;
        rchk(8'h30, 32'h8ff);
        rchk(8'h38, 32'h0);
        rchk(8'h3c, 32'h0);
        rchk(8'h50, 32'h0);
        rchk(8'h34, 32'h14);
        chk(irq, 32'h1);
    endtask
    task t_thr;
        @(posedge clk_i);
        txl <= 8'h03;
        wreg(8'h3c, 32'h3);
        rchk(8'h34, 32'h14);
        wreg(8'h3c, 32'h2);
        wreg(8'h38, 32'h1);
        rchk(8'h38, 32'h1);
        rchk(8'h34, 32'h0);
        @(posedge clk_i);
        rxl <= 8'h01;
        rchk(8'h34, 32'h4);
        @(posedge clk_i);
        rxl <= 8'h00;
    endtask
    task t_ce;
        @(posedge clk_i);
        ce <= 1'b0;
        wreg(8'h3c, 32'h5);
        pulse(12'h020);
        @(posedge clk_i);
        ce <= 1'b1;
        rchk(8'h3c, 32'h2);
        rchk(8'h34, 32'h0);
    endtask
    task t_ev;
        @(posedge clk_i);
        fl <= 1'b1;
        foreach (bits[i]) begin
            pulse(12'h1 << bits[i]);
            rchk(8'h34, 32'h1 << bits[i]);
            rchk(8'h40, (32'h8ff >> bits[i]) & 32'h1);
            rchk(8'h34, 32'h0);
        end
        pulse(12'h001);
        rchk(8'h44, 32'h1);
        rchk(8'h34, 32'h0);
        @(posedge clk_i);
        fl <= 1'b0;
        pulse(12'h00b);
        rchk(8'h34, 32'h0);
    endtask
    task t_bus;
        wreg(8'h30, 32'h400);
        rchk(8'h30, 32'h400);
        @(posedge clk_i);
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
        rchk(8'h34, 32'h700);
        rchk(8'h2c, 32'h400);
        chk(irq, 32'h1);
        rchk(8'h40, 32'h1);
        rchk(8'h34, 32'h0);
        chk(irq, 32'h0);
    endtask
    task t_rst2;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rchk(8'h30, 32'h8ff);
        rchk(8'h3c, 32'h0);
    endtask
    task finish_test;
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_thr;
        t_ce;
        t_ev;
        t_bus;
        t_rst2;
        finish_test;
    end
endmodule
